// [verilog/dbt_pkg.sv]
// Package for the debug bus trigger block: register map, fields, modes, carriers.
// Assumes a single core bus clock and a plain strobe register port.
package dbt_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int BUS_ODD_BIT = 0; // Address bit that marks an odd byte lane
	localparam int REG_AW = 4;
	localparam int REG_DW = 16;

	// Register offsets
	localparam logic [REG_AW-1:0] OFS_CTRL    = 4'h0;
	localparam logic [REG_AW-1:0] OFS_STATUS  = 4'h1;
	localparam logic [REG_AW-1:0] OFS_CMPA    = 4'h2;
	localparam logic [REG_AW-1:0] OFS_CMPB    = 4'h3;
	localparam logic [REG_AW-1:0] OFS_IRQ_ST  = 4'h4;
	localparam logic [REG_AW-1:0] OFS_IRQ_EN  = 4'h5;
	localparam logic [REG_AW-1:0] OFS_IRQ_CLR = 4'h6;
	localparam logic [REG_AW-1:0] OFS_MATCH_A = 4'h7;
	localparam logic [REG_AW-1:0] OFS_MATCH_B = 4'h8;

	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W   = 3;
	localparam int CTRL_BEGIN    = 4;
	localparam int CTRL_TRGSRC   = 5;
	localparam int CTRL_DETAIL   = 6;
	localparam int CTRL_ARM      = 7;
	localparam int CTRL_FASTMIS  = 8;
	localparam logic [REG_DW-1:0] CTRL_RST = 16'h0000;

	// Status register fields
	localparam int ST_AF   = 0;
	localparam int ST_BF   = 1;
	localparam int ST_TRIG = 2;
	localparam int ST_ARMD = 3;
	localparam int ST_ASEEN = 4;

	// Interrupt events
	localparam int IRQ_W     = 3;
	localparam int IRQ_MATCH_A = 0;
	localparam int IRQ_MATCH_B = 1;
	localparam int IRQ_TRIG    = 2;

	typedef enum logic [2:0] {
		DBT_MODE_A_ONLY   = 3'b000,
		DBT_MODE_A_OR_B   = 3'b001,
		DBT_MODE_A_THEN_B = 3'b010,
		DBT_MODE_EV_B     = 3'b011,
		DBT_MODE_A_THEN_EVB = 3'b100,
		DBT_MODE_A_AND_B  = 3'b101,
		DBT_MODE_A_NOT_B  = 3'b110,
		DBT_MODE_B_ONLY   = 3'b111
	} dbt_mode_t;

	typedef struct packed {
		logic              valid;
		logic              tag_a;
		logic              word;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} dbt_bus_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [REG_AW-1:0] addr;
		logic [REG_DW-1:0] wdata;
	} dbt_reg_req_t;

endpackage : dbt_pkg

// [verilog/dbt_cmp.sv]
// Single comparator with its own value register and match output.
// Assumes bus fields are already sampled on mclk.
`timescale 1ns/1ns
module dbt_cmp #(
	parameter int W = 16
) (
	input  wire logic         mclk,  // Core bus clock
	input  wire logic         srst,  // Sync reset
	input  wire logic         load,  // Load compare value
	input  wire logic [W-1:0] value, // New compare value
	input  wire logic [W-1:0] probe, // Observed bus value
	output logic      [W-1:0] ref_v, // Stored compare value
	output logic              hit    // Combinational equality
);
	always_ff @(posedge mclk) begin
		if (srst) begin
			ref_v <= '0;
		end else if (load) begin
			ref_v <= value;
		end
	end

	assign hit = (probe == ref_v);
endmodule : dbt_cmp

// [verilog/dbt_trigger.sv]
// Comparator trigger logic of the debug module: two comparators, mode select,
// sticky match flags, trigger output and interrupt. Assumes one core bus clock.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
// Function
// - Event-only B: each B match sets B flag and triggers.
// - Event-only B is begin-type; begin bit ignored.
// - Event-only B ignores the trigger source select bit.
// - Detail capture with event-only B: act as B-only, bits honoured.
// - A then event-only B: B checked after A; trigger on every B.
// - A then event-only B: each A match sets A flag; each B match after A sets B flag.
// - A then event-only B is begin-type; begin bit ignored.
// - A then event-only B: source select applies only to A.
// - Detail capture with A then event-only B: act as A then B.
// - Full modes: A compares address, B compares data.
// - A and B: same-cycle matches set both flags and trigger.
// - Full modes with source select one: trigger from A only (B-only never triggers), except A then B, still triggered by B after A.
// - Source select zero: misaligned word data matches only with fast memory.
// - A and not B: A without B sets both flags and triggers.
// - A and not B: failed misaligned word compare triggers unless fast memory.
module dbt_trigger
	import dbt_pkg::*;
(
	input  wire logic                  mclk,      // Core bus clock
	input  wire logic                  srst,      // Sync reset, high
	input  wire dbt_pkg::dbt_reg_req_t reg_req,   // Register strobes
	output logic [dbt_pkg::REG_DW-1:0] reg_rdata, // Read data, next cycle
	input  wire dbt_pkg::dbt_bus_t     core_bus,  // Core bus cycle
	output logic                       trig,      // Trigger pulse
	output logic                       trig_begin,// Begin-type trigger
	output logic                       irq        // Interrupt level
);
	import dbt_pkg::*;

	function automatic logic hit_reg(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] ofs);
		hit_reg = (a == ofs);
	endfunction : hit_reg

	logic [REG_DW-1:0] ctrl;
	logic              flag_a;
	logic              flag_b;
	logic              flag_trig;
	logic              a_seen;
	logic [IRQ_W-1:0]  irq_st;
	logic [IRQ_W-1:0]  irq_en;
	logic [ADDR_W-1:0] ref_a;
	logic [DATA_W-1:0] ref_b;
	logic              raw_a;
	logic              raw_b;

	dbt_mode_t mode;
	logic      begin_bit;
	logic      trgsrc;
	logic      detail;
	logic      fast_mis;
	logic      wr_ctrl;
	logic      rearm;

	assign mode      = dbt_mode_t'(ctrl[CTRL_MODE_LSB +: CTRL_MODE_W]);
	assign begin_bit = ctrl[CTRL_BEGIN];
	assign trgsrc    = ctrl[CTRL_TRGSRC];
	assign detail    = ctrl[CTRL_DETAIL];
	assign fast_mis  = ctrl[CTRL_FASTMIS];
	assign wr_ctrl   = reg_req.wr && hit_reg(reg_req.addr, OFS_CTRL);
	assign rearm     = wr_ctrl && reg_req.wdata[CTRL_ARM];

	// Register write decodes, one per target
	logic      wr_cmpa;
	logic      wr_cmpb;
	logic      wr_status;
	logic      wr_irq_en;
	logic      wr_irq_clr;
	assign wr_cmpa    = reg_req.wr && hit_reg(reg_req.addr, OFS_CMPA);
	assign wr_cmpb    = reg_req.wr && hit_reg(reg_req.addr, OFS_CMPB);
	assign wr_status  = reg_req.wr && hit_reg(reg_req.addr, OFS_STATUS);
	assign wr_irq_en  = reg_req.wr && hit_reg(reg_req.addr, OFS_IRQ_EN);
	assign wr_irq_clr = reg_req.wr && hit_reg(reg_req.addr, OFS_IRQ_CLR);

	// Comparator A on address, B on data
	dbt_cmp #(.W(ADDR_W)) u_cmp_a (
		.mclk  (mclk),
		.srst  (srst),
		.load  (wr_cmpa),
		.value (reg_req.wdata[ADDR_W-1:0]),
		.probe (core_bus.addr),
		.ref_v (ref_a),
		.hit   (raw_a)
	);

	dbt_cmp #(.W(DATA_W)) u_cmp_b (
		.mclk  (mclk),
		.srst  (srst),
		.load  (wr_cmpb),
		.value (reg_req.wdata),
		.probe (core_bus.data),
		.ref_v (ref_b),
		.hit   (raw_b)
	);

	// Effective mode after detail capture override
	// Detail capture takes over both event modes and restores the plain variants
	dbt_mode_t eff_mode;
	always_comb begin
		eff_mode = mode;
		if (detail && mode == DBT_MODE_EV_B) begin
			eff_mode = DBT_MODE_B_ONLY;
		end else if (detail && mode == DBT_MODE_A_THEN_EVB) begin
			eff_mode = DBT_MODE_A_THEN_B;
		end
	end

	// Misaligned word data cannot match unless memory completes it in one cycle
	logic misaligned;
	logic b_valid_data;
	assign misaligned   = core_bus.word && core_bus.addr[BUS_ODD_BIT] && !fast_mis;
	assign b_valid_data = raw_b && !misaligned;

	// A match: tag source when selected, except in event-only B; B never tag-qualified
	logic a_match;
	logic b_match;
	logic a_uses_tag;
	always_comb begin
		a_uses_tag = trgsrc;
		if (eff_mode == DBT_MODE_EV_B) begin
			a_uses_tag = 1'b0;
		end
	end
	assign a_match = core_bus.valid && (a_uses_tag ? core_bus.tag_a : raw_a);
	assign b_match = core_bus.valid && b_valid_data;

	logic next_set_a;
	logic next_set_b;
	logic next_trig;
	logic next_begin;

	// Per-mode set and trigger terms; the arm bit is applied at the flops
	always_comb begin
		next_set_a = 1'b0;
		next_set_b = 1'b0;
		next_trig  = 1'b0;
		next_begin = begin_bit;
		case (eff_mode)
			DBT_MODE_A_ONLY: begin
				next_set_a = a_match;
				next_trig  = a_match;
			end
			DBT_MODE_A_OR_B: begin
				next_set_a = a_match;
				next_set_b = b_match && !trgsrc;
				next_trig  = next_set_a || next_set_b;
			end
			DBT_MODE_A_THEN_B: begin
				next_set_a = a_match && !a_seen;
				next_set_b = b_match && a_seen && !flag_b;
				next_trig  = next_set_b;
			end
			DBT_MODE_EV_B: begin
				next_set_b = b_match;
				next_trig  = b_match;
				next_begin = 1'b1;
			end
			DBT_MODE_A_THEN_EVB: begin
				next_set_a = a_match;
				next_set_b = b_match && a_seen;
				next_trig  = next_set_b;
				next_begin = 1'b1;
			end
			DBT_MODE_A_AND_B: begin
				if (trgsrc) begin
					next_set_a = a_match;
					next_trig  = a_match;
				end else begin
					next_set_a = a_match && b_match;
					next_set_b = next_set_a;
					next_trig  = next_set_a;
				end
			end
			DBT_MODE_A_NOT_B: begin
				if (trgsrc) begin
					next_set_a = a_match;
					next_trig  = a_match;
				end else begin
					next_set_a = a_match && !b_valid_data;
					next_set_b = next_set_a;
					next_trig  = next_set_a;
				end
			end
			DBT_MODE_B_ONLY: begin
				next_set_b = b_match && !trgsrc;
				next_trig  = next_set_b;
			end
			default: begin
				next_trig = 1'b0;
			end
		endcase
	end

	// Arm bit gates every set; a rearm write clears the match history
	logic armed;
	assign armed = ctrl[CTRL_ARM];

	// Control register
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl <= reg_req.wdata;
		end
	end

	// Sticky match flags; set wins over clear so a match in the clearing cycle is kept
	logic clr_flags;
	assign clr_flags = rearm || wr_status;

	// A match flag
	always_ff @(posedge mclk) begin
		if (srst) begin
			flag_a <= 1'b0;
		end else begin
			flag_a <= (armed && next_set_a) || (flag_a && !clr_flags);
		end
	end

	// B match flag
	always_ff @(posedge mclk) begin
		if (srst) begin
			flag_b <= 1'b0;
		end else begin
			flag_b <= (armed && next_set_b) || (flag_b && !clr_flags);
		end
	end

	// Trigger seen flag
	always_ff @(posedge mclk) begin
		if (srst) begin
			flag_trig <= 1'b0;
		end else begin
			flag_trig <= (armed && next_trig) || (flag_trig && !clr_flags);
		end
	end

	// A seen; gates B in the sequential modes
	always_ff @(posedge mclk) begin
		if (srst) begin
			a_seen <= 1'b0;
		end else begin
			a_seen <= (armed && a_match) || (a_seen && !clr_flags);
		end
	end

	// Trigger pulse, one cycle per trigger
	always_ff @(posedge mclk) begin
		if (srst) begin
			trig <= 1'b0;
		end else begin
			trig <= armed && next_trig;
		end
	end

	// Begin-type pulse, never without trig
	always_ff @(posedge mclk) begin
		if (srst) begin
			trig_begin <= 1'b0;
		end else begin
			trig_begin <= armed && next_trig && next_begin;
		end
	end

	// Interrupt status, enable, clear
	logic [IRQ_W-1:0] irq_ev;
	logic [IRQ_W-1:0] irq_clr;
	assign irq_ev[IRQ_MATCH_A] = armed && next_set_a;
	assign irq_ev[IRQ_MATCH_B] = armed && next_set_b;
	assign irq_ev[IRQ_TRIG]    = armed && next_trig;
	assign irq_clr = wr_irq_clr ? reg_req.wdata[IRQ_W-1:0] : '0;

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_st <= '0;
		end else begin
			irq_st <= irq_ev | (irq_st & ~irq_clr);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_en <= '0;
		end else if (wr_irq_en) begin
			irq_en <= reg_req.wdata[IRQ_W-1:0];
		end
	end

	// Level output; stays high until software clears the status bit
	assign irq = |(irq_st & irq_en);

	// Read data, one cycle after the strobe
	logic [REG_DW-1:0] next_rdata;
	always_comb begin
		next_rdata = '0;
		case (reg_req.addr)
			OFS_CTRL: begin
				next_rdata = ctrl;
			end
			OFS_STATUS: begin
				next_rdata[ST_AF]    = flag_a;
				next_rdata[ST_BF]    = flag_b;
				next_rdata[ST_TRIG]  = flag_trig;
				next_rdata[ST_ARMD]  = armed;
				next_rdata[ST_ASEEN] = a_seen;
			end
			OFS_CMPA: begin
				next_rdata[ADDR_W-1:0] = ref_a;
			end
			OFS_CMPB: begin
				next_rdata[DATA_W-1:0] = ref_b;
			end
			OFS_IRQ_ST: begin
				next_rdata[IRQ_W-1:0] = irq_st;
			end
			OFS_IRQ_EN: begin
				next_rdata[IRQ_W-1:0] = irq_en;
			end
			// Live comparator hits, for checking the setup
			OFS_MATCH_A: begin
				next_rdata[0] = raw_a;
			end
			OFS_MATCH_B: begin
				next_rdata[0] = raw_b;
			end
			default: begin
				next_rdata = '0;
			end
		endcase
	end

	// Zero outside the answer cycle so stale data never looks valid
	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (reg_req.rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule : dbt_trigger

// [verif/dbt_trigger_properties.sv]
// Checker for the debug bus trigger block, bound to its top module.
// Assumes registers and bus as in dbt_pkg; shadows track control writes.
`timescale 1ns/1ns
module dbt_trigger_chk
	import dbt_pkg::*;
(
	input wire logic                  mclk,       // Core bus clock
	input wire logic                  srst,       // Sync reset
	input wire dbt_pkg::dbt_reg_req_t reg_req,    // Register strobes
	input wire logic [dbt_pkg::REG_DW-1:0] reg_rdata, // Read data
	input wire dbt_pkg::dbt_bus_t     core_bus,   // Core bus cycle
	input wire logic                  trig,       // Trigger pulse
	input wire logic                  trig_begin, // Begin trigger
	input wire logic                  irq         // Interrupt level
);
	logic [REG_DW-1:0] ctrl;
	logic [REG_DW-1:0] ref_a;
	logic [REG_DW-1:0] ref_b;
	logic              aseen;
	logic [2:0]        md;
	logic              go;
	logic              ha;
	logic              hb;
	logic              ev;
	logic              ha_src;
	assign md = ctrl[2:0];
	assign ha_src = ctrl[CTRL_TRGSRC] ? core_bus.tag_a : core_bus.addr == ref_a;
	assign go = core_bus.valid && ctrl[CTRL_ARM];
	assign ha = core_bus.addr == ref_a;
	assign hb = core_bus.data == ref_b && !(core_bus.word && core_bus.addr[0] && !ctrl[CTRL_FASTMIS]);
	assign ev = !ctrl[CTRL_DETAIL];
	always_ff @(posedge mclk) begin
		if (srst)
			ctrl <= CTRL_RST;
		else if (reg_req.wr && reg_req.addr == OFS_CTRL)
			ctrl <= reg_req.wdata;
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			ref_a <= '0;
			ref_b <= '0;
		end else begin
			if (reg_req.wr && reg_req.addr == OFS_CMPA)
				ref_a <= reg_req.wdata;
			if (reg_req.wr && reg_req.addr == OFS_CMPB)
				ref_b <= reg_req.wdata;
		end
	end
	// A seen: source select qualifies A only; status write or rearm clears, set wins
	always_ff @(posedge mclk) begin
		if (srst)
			aseen <= 1'b0;
		else if (go && md == DBT_MODE_A_THEN_EVB && ha_src)
			aseen <= 1'b1;
		else if (reg_req.wr && (reg_req.addr == OFS_STATUS || reg_req.addr == OFS_CTRL && reg_req.wdata[CTRL_ARM]))
			aseen <= 1'b0;
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	sequence evb_hit;
		go && md == DBT_MODE_A_THEN_EVB && ev && aseen && hb;
	endsequence
	sequence evb_early;
		go && md == DBT_MODE_A_THEN_EVB && ev && !aseen;
	endsequence
	rd_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside read answer");
	unmapped_rd_a: assert property (reg_req.rd && reg_req.addr > OFS_MATCH_B |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	begin_pulse_a: assert property (trig_begin |-> trig)
		else $error("begin pulse without trigger");
	trig_cause_a: assert property (trig |-> $past(go))
		else $error("trigger without armed bus cycle");
	evb_fire_a: assert property (go && md == DBT_MODE_EV_B && ev && hb |=> trig && trig_begin)
		else $error("event B match did not trigger");
	evb_quiet_a: assert property (go && md == DBT_MODE_EV_B && ev && !hb |=> !trig)
		else $error("event B trigger without match");
	thenb_fire_a: assert property (evb_hit |=> trig && trig_begin)
		else $error("B after A did not trigger");
	thenb_wait_a: assert property (evb_early |=> !trig)
		else $error("trigger before A seen");
	andb_fire_a: assert property (go && md == DBT_MODE_A_AND_B && !ctrl[CTRL_TRGSRC] && ha && hb |=> trig)
		else $error("A and B match did not trigger");
	andb_quiet_a: assert property (go && md == DBT_MODE_A_AND_B && !ctrl[CTRL_TRGSRC] && !(ha && hb) |=> !trig)
		else $error("A and B trigger without both");
	notb_fire_a: assert property (go && md == DBT_MODE_A_NOT_B && !ctrl[CTRL_TRGSRC] && ha && !hb |=> trig)
		else $error("A not B did not trigger");
	notb_quiet_a: assert property (go && md == DBT_MODE_A_NOT_B && !ctrl[CTRL_TRGSRC] && ha && hb |=> !trig)
		else $error("A not B trigger with B match");
endmodule : dbt_trigger_chk
bind dbt_trigger dbt_trigger_chk chk_u (.mclk(mclk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.core_bus(core_bus), .trig(trig), .trig_begin(trig_begin), .irq(irq));

// [verif/dbt_core_model.sv]
// Model of the processor core bus feeding the trigger comparators.
// Assumes callers start a cycle from any time; drives just after an edge.
`timescale 1ns/1ns
module dbt_core_model
	import dbt_pkg::*;
(
	input  wire logic         mclk,     // Core bus clock
	output dbt_pkg::dbt_bus_t core_bus  // Driven bus cycle
);
	initial core_bus = '0;
	task automatic xfer(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w, input logic t);
		@(posedge mclk);
		core_bus <= '{1'b1, t, w, a, d};
		@(posedge mclk);
		// Idle lines show the inverse, never a stale match
		core_bus <= '{1'b0, ~t, ~w, ~a, ~d};
	endtask : xfer
endmodule : dbt_core_model

// [verif/debug_bus_trigger_modes_bench.sv]
// Self-checking bench for the debug bus trigger block.
// Assumes the core model drives the bus and tasks drive the register port.
`timescale 1ns/1ns
module debug_bus_trigger_modes_bench;
	import dbt_pkg::*;
	logic         mclk;
	logic         srst;
	dbt_reg_req_t req;
	logic [15:0]  reg_rdata;
	dbt_bus_t     core_bus;
	logic         trig;
	logic         trig_begin;
	logic         irq;
	int           err_total;
	int           cmp_count;
	dbt_trigger dut_u (.mclk(mclk), .srst(srst), .reg_req(req), .reg_rdata(reg_rdata),
		.core_bus(core_bus), .trig(trig), .trig_begin(trig_begin), .irq(irq));
	dbt_core_model core_u (.mclk(mclk), .core_bus(core_bus));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge mclk);
		req <= '0;
		#1;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge mclk);
		req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge mclk);
		req <= '0;
		#1;
		chk(reg_rdata & m, e);
	endtask : rd_reg
	task automatic bus(input logic [15:0] a, input logic [15:0] d, input logic w, input logic t, input logic [1:0] e);
		core_u.xfer(a, d, w, t);
		#1;
		chk({14'h0, trig, trig_begin}, {14'h0, e});
	endtask : bus
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (3000) @(posedge mclk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		srst = 1'b1;
		req = '0;
		err_total = 0;
		cmp_count = 0;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		rd_reg(OFS_CTRL, 16'h0000, 16'hffff);
		rd_reg(OFS_STATUS, 16'h0000, 16'hffff);
		wr_reg(4'h9, 16'hffff);
		rd_reg(4'h9, 16'h0000, 16'hffff);
		wr_reg(OFS_CMPA, 16'h2000);
		rd_reg(OFS_CMPA, 16'h2000, 16'hffff);
		wr_reg(OFS_CMPB, 16'h5a5a);
		$display("test regs done");
		// Event B armed, source select set, begin clear
		wr_reg(OFS_CTRL, 16'h00a3);
		bus(16'h1234, 16'h5a5a, 1'b0, 1'b0, 2'b11);
		bus(16'h1235, 16'h5a5a, 1'b0, 1'b1, 2'b11);
		bus(16'h1234, 16'h5a5b, 1'b0, 1'b0, 2'b00);
		rd_reg(OFS_STATUS, 16'h000e, 16'h000f);
		wr_reg(OFS_STATUS, 16'h0000);
		rd_reg(OFS_STATUS, 16'h0008, 16'h000f);
		wr_reg(OFS_CTRL, 16'h00c3);
		bus(16'h1234, 16'h5a5a, 1'b0, 1'b0, 2'b10);
		$display("test event_b done");
		wr_reg(OFS_CTRL, 16'h0084);
		bus(16'h1234, 16'h5a5a, 1'b0, 1'b0, 2'b00);
		bus(16'h2000, 16'h0000, 1'b0, 1'b0, 2'b00);
		bus(16'h1234, 16'h5a5a, 1'b0, 1'b0, 2'b11);
		bus(16'h1234, 16'h5a5a, 1'b0, 1'b0, 2'b11);
		rd_reg(OFS_STATUS, 16'h001f, 16'h001f);
		wr_reg(OFS_CTRL, 16'h00a4);
		bus(16'h2000, 16'h0000, 1'b0, 1'b0, 2'b00);
		bus(16'h1234, 16'h5a5a, 1'b0, 1'b0, 2'b00);
		bus(16'h2000, 16'h0000, 1'b0, 1'b1, 2'b00);
		bus(16'h1234, 16'h5a5a, 1'b0, 1'b0, 2'b11);
		wr_reg(OFS_CTRL, 16'h00c4);
		bus(16'h2000, 16'h0000, 1'b0, 1'b0, 2'b00);
		bus(16'h1234, 16'h5a5a, 1'b0, 1'b0, 2'b10);
		bus(16'h1234, 16'h5a5a, 1'b0, 1'b0, 2'b00);
		$display("test a_then_b done");
		wr_reg(OFS_CTRL, 16'h0005);
		bus(16'h2000, 16'h5a5a, 1'b0, 1'b0, 2'b00);
		wr_reg(OFS_CTRL, 16'h0085);
		bus(16'h2000, 16'h5a5a, 1'b0, 1'b0, 2'b10);
		bus(16'h2000, 16'h5a5b, 1'b0, 1'b0, 2'b00);
		bus(16'h2002, 16'h5a5a, 1'b0, 1'b0, 2'b00);
		wr_reg(OFS_CMPA, 16'h2001);
		bus(16'h2001, 16'h5a5a, 1'b1, 1'b0, 2'b00);
		wr_reg(OFS_CTRL, 16'h0185);
		bus(16'h2001, 16'h5a5a, 1'b1, 1'b0, 2'b10);
		wr_reg(OFS_CTRL, 16'h00a5);
		bus(16'h2001, 16'h0000, 1'b0, 1'b1, 2'b10);
		$display("test a_and_b done");
		wr_reg(OFS_CTRL, 16'h0086);
		bus(16'h2001, 16'h0000, 1'b0, 1'b0, 2'b10);
		rd_reg(OFS_STATUS, 16'h000f, 16'h000f);
		bus(16'h2001, 16'h5a5a, 1'b0, 1'b0, 2'b00);
		bus(16'h2001, 16'h5a5a, 1'b1, 1'b0, 2'b10);
		wr_reg(OFS_CTRL, 16'h00a6);
		bus(16'h2001, 16'h5a5a, 1'b0, 1'b1, 2'b10);
		$display("test a_not_b done");
		wr_reg(OFS_IRQ_EN, 16'h0000);
		wr_reg(OFS_IRQ_CLR, 16'h0007);
		chk({15'h0, irq}, 16'h0000);
		bus(16'h2001, 16'h5a5a, 1'b0, 1'b1, 2'b10);
		chk({15'h0, irq}, 16'h0000);
		rd_reg(OFS_IRQ_ST, 16'h0004, 16'h0004);
		wr_reg(OFS_IRQ_EN, 16'h0004);
		chk({15'h0, irq}, 16'h0001);
		wr_reg(OFS_IRQ_CLR, 16'h0004);
		chk({15'h0, irq}, 16'h0000);
		rd_reg(OFS_IRQ_ST, 16'h0000, 16'h0004);
		$display("test irq done");
		// Idle bus shows the inverse of the last cycle: addr dffe, data a5a5
		wr_reg(OFS_CMPA, 16'hdffe);
		rd_reg(OFS_MATCH_A, 16'h0001, 16'hffff);
		rd_reg(OFS_MATCH_B, 16'h0000, 16'hffff);
		// Reset in mid-run clears compare values and disarms
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		rd_reg(OFS_CMPA, 16'h0000, 16'hffff);
		rd_reg(OFS_STATUS, 16'h0000, 16'hffff);
		$display("test raw_reset done");
		tally_and_finish();
	end
endmodule : debug_bus_trigger_modes_bench
